// File: rtl/iqcm_pkg.sv
// Package of offsets, field layouts, reset values and carriers for the queue congestion monitor.
package iqcm_pkg;

  // Per-port registers; port p sits at offset + p * PORT_STRIDE.
  localparam logic [31:0] DEPTH_CFG_OFS = 32'h0001_3090;
  localparam logic [31:0] EVT_STATUS_OFS = 32'h0001_3094;
  localparam logic [31:0] DURATION_OFS = 32'h0001_3098;
  localparam logic [31:0] PORT_STRIDE = 32'h0000_0100;
  // Block-wide registers.
  localparam logic [31:0] IRQ_STATUS_OFS = 32'h0001_3800;
  localparam logic [31:0] IRQ_MASK_OFS = 32'h0001_3804;
  localparam logic [31:0] BIAS_INTERVAL_OFS = 32'h0001_3808;

  // Bit 0 of the register map is the least significant bus bit.
  localparam int EVT_COUNT_LSB = 16;
  localparam int EVT_LIMIT_LSB = 0;
  localparam int PERIOD_LSB = 16;
  localparam int DEPTH_LSB = 12;

  localparam logic [15:0] EVT_SAT = 16'hFFFF;
  localparam logic [31:0] DUR_SAT = 32'h0000_FFFF;
  localparam logic [3:0] DEPTH_MAX = 4'h7;

  localparam logic [15:0] EVT_COUNT_RST = 16'h0000;
  localparam logic [15:0] EVT_LIMIT_RST = 16'h0000;
  localparam logic [31:0] DUR_COUNT_RST = 32'h0000_0000;
  localparam logic [15:0] PERIOD_RST = 16'h0000;
  localparam logic [3:0] DEPTH_RST = 4'h0;
  localparam logic [31:0] BIAS_INTERVAL_RST = 32'h0000_0000;

  // Fill level and packet strobe that the input buffer logic presents per port.
  typedef struct packed {
    logic [3:0] fill;
    logic pkt_rx;
  } iqcm_fill_s;

  // One register access as the bus front end hands it over.
  typedef struct packed {
    logic rd;
    logic wr;
    logic [31:0] addr;
    logic [31:0] wdata;
  } iqcm_req_s;

  function automatic logic [31:0] iqcm_sat_inc(input logic [31:0] v, input logic [31:0] lim);
    return (v >= lim) ? v : v + 32'h0000_0001;
  endfunction

endpackage

// File: rtl/iqcm_ahb.sv
// AHB-Lite slave front end that turns bus transfers into single-cycle register strobes.
module iqcm_ahb (
  input wire logic clk, // Core clock.
  input wire logic resetn, // Synchronous reset, active low.
  input wire logic hsel, // Slave select.
  input wire logic [31:0] haddr, // Byte address.
  input wire logic [1:0] htrans, // Transfer type.
  input wire logic hwrite, // Write when high.
  input wire logic [2:0] hsize, // Transfer size.
  input wire logic hready, // Bus ready.
  input wire logic [31:0] hwdata, // Write data.
  input wire logic [31:0] rdata, // Read data of the addressed register.
  output logic [31:0] hrdata, // Read data to the master.
  output logic hreadyout, // Slave ready.
  output logic hresp, // Always OKAY.
  output iqcm_pkg::iqcm_req_s req // Register access strobes.
);
  typedef enum logic [1:0] {IQCM_IDLE, IQCM_WR_DATA, IQCM_RD_FETCH, IQCM_RD_DATA} iqcm_bus_e;

  iqcm_bus_e state_reg;
  iqcm_bus_e state_next;
  logic [31:0] addr_reg;
  logic word_reg;
  logic [31:0] hrdata_reg;
  logic accept;

  // Reads take one wait state so that a write just before them is already visible.
  assign accept = hsel && htrans[1] && hready;
  assign hreadyout = (state_reg != IQCM_RD_FETCH);
  assign hresp = 1'b0;
  assign hrdata = hrdata_reg;
  assign req.rd = (state_reg == IQCM_RD_FETCH);
  assign req.wr = (state_reg == IQCM_WR_DATA) && word_reg;
  assign req.addr = addr_reg;
  assign req.wdata = hwdata;

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      IQCM_RD_FETCH: state_next = IQCM_RD_DATA;
      default: state_next = accept ? (hwrite ? IQCM_WR_DATA : IQCM_RD_FETCH) : IQCM_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      state_reg <= IQCM_IDLE;
      addr_reg <= 32'h0000_0000;
      word_reg <= 1'b0;
      hrdata_reg <= 32'h0000_0000;
    end else begin
      state_reg <= state_next;
      if (accept && hreadyout) begin
        addr_reg <= haddr;
        word_reg <= (hsize == 3'h2);
      end
      if (state_reg == IQCM_RD_FETCH) begin
        hrdata_reg <= rdata;
      end
    end
  end

  read_wait_a: assert property (@(posedge clk) disable iff (!resetn)
    req.rd |=> hreadyout && !req.rd) else $error("read wait state longer than one cycle");
  cover_read_c: cover property (@(posedge clk) disable iff (!resetn) req.rd ##1 accept);
endmodule

// File: rtl/iqcm_port.sv
// One port's congestion event counter and congestion duration counter.
module iqcm_port (
  input wire logic clk, // Core clock.
  input wire logic resetn, // Synchronous reset, active low.
  input wire iqcm_pkg::iqcm_fill_s fill_in, // Buffer fill and packet strobe.
  input wire logic [3:0] depth, // Depth threshold field.
  input wire logic [15:0] period, // Duration tick divisor.
  input wire logic [15:0] limit, // Congestion event limit.
  input wire logic [31:0] wdata, // Register write data.
  input wire logic evt_wr, // Load of the event status register.
  input wire logic evt_clear, // Write of one to the interrupt flag.
  input wire logic evt_rd, // Read of the event status register.
  input wire logic dur_wr, // Load of the duration register.
  input wire logic dur_rd, // Read of the duration register.
  input wire logic bias_tick, // Error-rate bias interval pulse.
  output logic [15:0] evt_count, // Congestion event count.
  output logic [31:0] dur_count, // Congestion duration count.
  output logic evt_hit, // Pulse when the count reaches the limit.
  output logic congested // Input queue congested.
);
  logic [15:0] evt_cnt_reg;
  logic [15:0] evt_cnt_next;
  logic [31:0] dur_reg;
  logic [31:0] dur_next;
  logic [15:0] div_reg;
  logic [15:0] div_next;
  logic seen_reg;
  logic hit_prev_reg;
  logic evt_en;
  logic evt_inc;
  logic evt_dec;
  logic dur_tick;
  logic hit_now;

  assign congested = (depth != 4'h0) && (depth <= iqcm_pkg::DEPTH_MAX)
    && (fill_in.fill >= depth + 4'h1);
  assign evt_en = (limit != 16'h0000);
  assign evt_inc = evt_en && fill_in.pkt_rx && congested;
  assign evt_dec = evt_en && bias_tick && !seen_reg && !evt_rd && (evt_cnt_reg != 16'h0000);
  // A divisor lowered mid-count must not let the divider run past its match and wrap.
  assign dur_tick = congested && (period != 16'h0000)
    && (div_reg >= period - 16'h0001);
  assign hit_now = evt_en && (evt_cnt_reg >= limit);
  assign evt_hit = hit_now && !hit_prev_reg;
  assign evt_count = evt_cnt_reg;
  assign dur_count = dur_reg;

  always_comb begin
    evt_cnt_next = evt_cnt_reg;
    if (evt_wr) begin
      evt_cnt_next = wdata[iqcm_pkg::EVT_COUNT_LSB +: 16];
    end else if (evt_clear) begin
      evt_cnt_next = 16'h0000;
    end else if (evt_inc) begin
      evt_cnt_next = 16'(iqcm_pkg::iqcm_sat_inc(32'(evt_cnt_reg), 32'(iqcm_pkg::EVT_SAT)));
    end else if (evt_dec) begin
      evt_cnt_next = evt_cnt_reg - 16'h0001;
    end
  end

  // A read in the same cycle as the clear still loses no tick.
  always_comb begin
    dur_next = dur_reg;
    if (dur_wr) begin
      dur_next = wdata;
    end else if (dur_rd) begin
      dur_next = dur_tick ? 32'h0000_0001 : 32'h0000_0000;
    end else if (dur_tick) begin
      dur_next = iqcm_pkg::iqcm_sat_inc(dur_reg, iqcm_pkg::DUR_SAT);
    end
  end

  // Only continuous congestion accumulates toward a tick.
  assign div_next = (!congested || dur_tick || period == 16'h0000)
    ? 16'h0000 : div_reg + 16'h0001;

  always_ff @(posedge clk) begin
    if (!resetn) begin
      evt_cnt_reg <= iqcm_pkg::EVT_COUNT_RST;
      dur_reg <= iqcm_pkg::DUR_COUNT_RST;
      div_reg <= 16'h0000;
      seen_reg <= 1'b0;
      hit_prev_reg <= 1'b0;
    end else begin
      evt_cnt_reg <= evt_cnt_next;
      dur_reg <= dur_next;
      div_reg <= div_next;
      seen_reg <= bias_tick ? 1'b0 : (seen_reg || evt_rd);
      hit_prev_reg <= hit_now;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  depth_map_a: assert property (depth > iqcm_pkg::DEPTH_MAX || depth == 4'h0 |-> !congested)
    else $error("congestion declared with monitoring disabled");
  count_step_a: assert property (evt_inc && !evt_wr && !evt_clear
    && evt_cnt_reg != 16'hFFFF |=> evt_cnt_reg == $past(evt_cnt_reg) + 16'h0001)
    else $error("event count missed a packet");
  count_sat_a: assert property (evt_cnt_reg == 16'hFFFF && !evt_wr && !evt_clear
    && !evt_dec |=> evt_cnt_reg == 16'hFFFF) else $error("event count wrapped");
  count_load_a: assert property (evt_wr |=> evt_cnt_reg == $past(wdata[31:16]))
    else $error("event count load failed");
  count_clear_a: assert property (evt_clear && !evt_wr |=> evt_cnt_reg == 16'h0000)
    else $error("event count not cleared");
  limit_off_a: assert property (limit == 16'h0000 && !evt_wr && !evt_clear
    |=> $stable(evt_cnt_reg)) else $error("event count moved while disabled");
  bias_dec_a: assert property (evt_dec && !evt_wr && !evt_clear && !evt_inc
    |=> evt_cnt_reg == $past(evt_cnt_reg) - 16'h0001) else $error("bias decrement missing");
  hit_pulse_a: assert property (hit_now && !$past(hit_now) |-> evt_hit)
    else $error("limit reached without event");
  dur_step_a: assert property (congested && period == 16'h0001 && !dur_wr && !dur_rd
    && dur_reg < 32'h0000_FFFF |=> dur_reg == $past(dur_reg) + 32'h1)
    else $error("duration count missed a clock");
  dur_clear_a: assert property (dur_rd && !dur_wr |=> dur_reg <= 32'h0000_0001)
    else $error("duration count not cleared by read");
  dur_off_a: assert property (period == 16'h0000 && !dur_wr && !dur_rd
    |=> $stable(dur_reg)) else $error("duration count moved while disabled");
  dur_sat_a: assert property (dur_reg >= 32'h0000_FFFF && !dur_wr && !dur_rd
    |=> $stable(dur_reg)) else $error("duration count passed its ceiling");
  div_restart_a: assert property (!congested |=> div_reg == 16'h0000)
    else $error("divider kept count across a gap");
  cover_sat_c: cover property (evt_cnt_reg == 16'hFFFE ##1 evt_cnt_reg == 16'hFFFF);
  cover_tick_c: cover property (dur_tick ##1 dur_tick);
endmodule

// File: rtl/iqcm_top.sv
// Input queue congestion monitor for all ports with its AHB-Lite register file and interrupt.
//
// Contract
// - Fill above depth means congested; the code declares it only for depth 1 to 7.
// - Count one event per packet while congested.
// - Event count saturates at all ones.
// - Software may load both counters.
// - Clearing the interrupt flag zeroes event count.
// - Zero event limit stops event counting.
// - Unread count decrements each bias interval.
// - Count reaching limit raises the interrupt flag.
// - Duration advances every N congested clocks.
// - Reading duration returns it, then clears.
// - Zero divisor disables the duration counter.
// - Duration count stops at sixteen ones.
// - Depth n declares congestion at n+1; the code does so for n from 1 to 7 only, and depth 0 or above 7 never congests.
// - Divisor one ticks every clock, maximum 64K.
module iqcm_top #(
  parameter int NPORT = 8
) (
  input wire logic clk, // Core clock, 40 MHz.
  input wire logic resetn, // Synchronous reset, active low.
  input wire logic hsel, // AHB slave select.
  input wire logic [31:0] haddr, // AHB address.
  input wire logic [1:0] htrans, // AHB transfer type.
  input wire logic hwrite, // AHB write.
  input wire logic [2:0] hsize, // AHB size.
  input wire logic hready, // AHB ready in.
  input wire logic [31:0] hwdata, // AHB write data.
  output logic [31:0] hrdata, // AHB read data.
  output logic hreadyout, // AHB ready out.
  output logic hresp, // AHB response.
  input wire iqcm_pkg::iqcm_fill_s [NPORT-1:0] port_in, // Per-port fill and packet strobe.
  output logic irq // Level interrupt.
);
  if (NPORT < 1 || NPORT > 8) begin : g_bad_nport
    $error("NPORT must lie between 1 and 8");
  end

  iqcm_pkg::iqcm_req_s bus_req;
  logic [31:0] rdata;
  logic [2:0] sel_port;
  logic [31:0] addr_base;
  logic port_ok;
  logic hit_depth;
  logic hit_evt;
  logic hit_dur;
  logic hit_irq_st;
  logic hit_irq_mask;
  logic hit_bias;

  logic [15:0] limit_reg [NPORT];
  logic [15:0] period_reg [NPORT];
  logic [3:0] depth_reg [NPORT];
  logic [15:0] evt_count [NPORT];
  logic [31:0] dur_count [NPORT];
  logic [NPORT-1:0] evt_hit;
  logic [NPORT-1:0] congested;
  logic [NPORT-1:0] evt_clear;

  logic [NPORT-1:0] irq_status_reg;
  logic [NPORT-1:0] irq_status_next;
  logic [NPORT-1:0] irq_mask_reg;
  logic [NPORT-1:0] status_clr;
  logic [31:0] bias_interval_reg;
  logic [31:0] bias_cnt_reg;
  logic [31:0] bias_cnt_next;
  logic bias_tick;

  iqcm_ahb u_ahb (
    .clk(clk),
    .resetn(resetn),
    .hsel(hsel),
    .haddr(haddr),
    .htrans(htrans),
    .hwrite(hwrite),
    .hsize(hsize),
    .hready(hready),
    .hwdata(hwdata),
    .rdata(rdata),
    .hrdata(hrdata),
    .hreadyout(hreadyout),
    .hresp(hresp),
    .req(bus_req)
  );

  // Address decode; the port index sits in address bits 10 to 8.
  assign sel_port = bus_req.addr[10:8];
  assign addr_base = {bus_req.addr[31:11], 3'h0, bus_req.addr[7:0]};
  assign port_ok = (int'(sel_port) < NPORT);
  assign hit_depth = port_ok && (addr_base == iqcm_pkg::DEPTH_CFG_OFS);
  assign hit_evt = port_ok && (addr_base == iqcm_pkg::EVT_STATUS_OFS);
  assign hit_dur = port_ok && (addr_base == iqcm_pkg::DURATION_OFS);
  assign hit_irq_st = (bus_req.addr == iqcm_pkg::IRQ_STATUS_OFS);
  assign hit_irq_mask = (bus_req.addr == iqcm_pkg::IRQ_MASK_OFS);
  assign hit_bias = (bus_req.addr == iqcm_pkg::BIAS_INTERVAL_OFS);

  // Unmapped addresses read as zero and ignore writes.
  always_comb begin
    rdata = 32'h0000_0000;
    if (hit_evt) begin
      rdata = {evt_count[sel_port], limit_reg[sel_port]};
    end else if (hit_dur) begin
      rdata = dur_count[sel_port];
    end else if (hit_depth) begin
      rdata = {period_reg[sel_port], depth_reg[sel_port], 12'h000};
    end else if (hit_irq_st) begin
      rdata = 32'(irq_status_reg);
    end else if (hit_irq_mask) begin
      rdata = 32'(irq_mask_reg);
    end else if (hit_bias) begin
      rdata = bias_interval_reg;
    end
  end

  // Writing a one to a status bit clears it together with that port's event count.
  assign status_clr = (bus_req.wr && hit_irq_st) ? bus_req.wdata[NPORT-1:0] : '0;
  assign evt_clear = status_clr;

  genvar p;
  generate
    for (p = 0; p < NPORT; p++) begin : g_port
      logic sel_this;
      assign sel_this = (sel_port == 3'(p));

      always_ff @(posedge clk) begin
        if (!resetn) begin
          limit_reg[p] <= iqcm_pkg::EVT_LIMIT_RST;
          period_reg[p] <= iqcm_pkg::PERIOD_RST;
          depth_reg[p] <= iqcm_pkg::DEPTH_RST;
        end else begin
          if (bus_req.wr && hit_evt && sel_this) begin
            limit_reg[p] <= bus_req.wdata[iqcm_pkg::EVT_LIMIT_LSB +: 16];
          end
          if (bus_req.wr && hit_depth && sel_this) begin
            period_reg[p] <= bus_req.wdata[iqcm_pkg::PERIOD_LSB +: 16];
            depth_reg[p] <= bus_req.wdata[iqcm_pkg::DEPTH_LSB +: 4];
          end
        end
      end

      iqcm_port u_port (
        .clk(clk),
        .resetn(resetn),
        .fill_in(port_in[p]),
        .depth(depth_reg[p]),
        .period(period_reg[p]),
        .limit(limit_reg[p]),
        .wdata(bus_req.wdata),
        .evt_wr(bus_req.wr && hit_evt && sel_this),
        .evt_clear(evt_clear[p]),
        .evt_rd(bus_req.rd && hit_evt && sel_this),
        .dur_wr(bus_req.wr && hit_dur && sel_this),
        .dur_rd(bus_req.rd && hit_dur && sel_this),
        .bias_tick(bias_tick),
        .evt_count(evt_count[p]),
        .dur_count(dur_count[p]),
        .evt_hit(evt_hit[p]),
        .congested(congested[p])
      );

      irq_set_a: assert property (@(posedge clk) disable iff (!resetn)
        evt_hit[p] |=> irq_status_reg[p]) else $error("event did not set its flag");
      irq_clear_a: assert property (@(posedge clk) disable iff (!resetn)
        status_clr[p] && !evt_hit[p] |=> !irq_status_reg[p] && evt_count[p] == 16'h0000)
        else $error("flag clear did not clear flag and count");
    end
  endgenerate

  // A new event in the clearing cycle keeps its flag set.
  assign irq_status_next = (irq_status_reg & ~status_clr) | evt_hit;
  assign irq = |(irq_status_reg & irq_mask_reg);

  // The bias interval is counted in core clocks; zero stops the decrement.
  assign bias_tick = (bias_interval_reg != 32'h0000_0000)
    && (bias_cnt_reg >= bias_interval_reg - 32'h0000_0001);
  assign bias_cnt_next = (bias_tick || bias_interval_reg == 32'h0000_0000)
    ? 32'h0000_0000 : bias_cnt_reg + 32'h0000_0001;

  always_ff @(posedge clk) begin
    if (!resetn) begin
      irq_status_reg <= '0;
      irq_mask_reg <= '0;
      bias_interval_reg <= iqcm_pkg::BIAS_INTERVAL_RST;
      bias_cnt_reg <= 32'h0000_0000;
    end else begin
      irq_status_reg <= irq_status_next;
      if (bus_req.wr && hit_irq_mask) begin
        irq_mask_reg <= bus_req.wdata[NPORT-1:0];
      end
      if (bus_req.wr && hit_bias) begin
        bias_interval_reg <= bus_req.wdata;
        bias_cnt_reg <= 32'h0000_0000;
      end else begin
        bias_cnt_reg <= bias_cnt_next;
      end
    end
  end

  irq_out_a: assert property (@(posedge clk) disable iff (!resetn)
    irq_status_reg[0] && irq_mask_reg[0] |-> irq) else $error("unmasked flag without interrupt");
  bias_period_a: assert property (@(posedge clk) disable iff (!resetn)
    bias_tick && bias_interval_reg != 32'h0000_0001 && !bus_req.wr
    |=> !bias_tick && bias_cnt_reg == 32'h0000_0000) else $error("bias interval spacing wrong");
  cover_irq_c: cover property (@(posedge clk) disable iff (!resetn) $rose(irq));
  cover_clear_c: cover property (@(posedge clk) disable iff (!resetn)
    (|irq_status_reg) ##1 (|status_clr));
endmodule

// File: tb/iqcm_fill_model.sv
// Behavioural model of the input buffer fill logic that feeds every monitored port.
module iqcm_fill_model #(
  parameter int NPORT = 8
) (
  input wire logic clk, // Core clock.
  input wire logic rnd_en, // Random traffic when high.
  input wire logic [3:0] fix_fill, // Fill level when traffic is fixed.
  input wire logic fix_pkt, // Packet strobe when traffic is fixed.
  output iqcm_pkg::iqcm_fill_s [NPORT-1:0] port_in // Fill and packet strobe per port.
);
  timeunit 1ns;
  timeprecision 1ps;
  initial port_in = '0;
  // Fills above eight are offered so that depth eight is seen never to congest.
  always @(posedge clk) begin
    for (int p = 0; p < NPORT; p++) begin
      if (rnd_en) begin
        port_in[p].fill <= 4'($urandom_range(15, 0));
        port_in[p].pkt_rx <= 1'($urandom_range(1, 0));
      end else begin
        port_in[p].fill <= fix_fill;
        port_in[p].pkt_rx <= fix_pkt;
      end
    end
  end
endmodule

// File: tb/tb_iqcm_top.sv
// Self-checking bench for the queue congestion monitor against a cycle model.
module tb_iqcm_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int NP = 8;
  logic clk, resetn, hsel, hwrite, hreadyout, hresp, irq, rnd_en, fix_pkt;
  logic [1:0] htrans;
  logic [2:0] hsize, sz;
  logic [3:0] fix_fill;
  logic [31:0] haddr, hwdata, hrdata, rd;
  iqcm_pkg::iqcm_fill_s [NP-1:0] port_in;
  int num_errors, tests_run, cyc;
  int m_evt[NP], m_dur[NP], m_div[NP], m_dep[NP], m_per[NP], m_lim[NP];
  logic [31:0] ra[7];

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  iqcm_fill_model #(.NPORT(NP)) fill_u (.clk(clk), .rnd_en(rnd_en), .fix_fill(fix_fill),
    .fix_pkt(fix_pkt), .port_in(port_in));

  iqcm_top #(.NPORT(NP)) dut_u (.clk(clk), .resetn(resetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hreadyout), .hwdata(hwdata),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .port_in(port_in), .irq(irq));

  // Reference model; it reads the same pre-edge values that the design samples.
  always @(posedge clk) begin
    if (resetn === 1'b1) begin
      for (int p = 0; p < NP; p++) begin
        if (m_dep[p] inside {[1:7]} && port_in[p].fill >= m_dep[p] + 1) begin
          if (port_in[p].pkt_rx && m_lim[p] != 0 && m_evt[p] < 65535) begin
            m_evt[p]++;
          end
          if (m_per[p] != 0) begin
            m_div[p]++;
            if (m_div[p] >= m_per[p]) begin
              m_div[p] = 0;
              if (m_dur[p] < 65535) m_dur[p]++;
            end
          end
        end else begin
          m_div[p] = 0;
        end
      end
    end
  end

  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      num_errors++;
      test_done();
    end
  end

  task automatic test_done();
    if (num_errors == 0 && tests_run > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %0t %s: got %h expected %h", $time, what, got, exp);
    end
  endtask

  // Holds each phase until hready is sampled high; no wait count is assumed.
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] wd);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= a;
    hwrite <= w;
    hsize <= sz;
    do @(posedge clk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge clk); while (hreadyout !== 1'b1);
    rd = hrdata;
    chk({31'h0, hresp}, 32'h0000_0000, "response not OKAY");
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask

  task automatic rdc(input logic [31:0] a, input logic [31:0] exp, input string what);
    bus(1'b0, a, 32'h0000_0000);
    chk(rd, exp, what);
  endtask

  function automatic logic [31:0] adr(input logic [31:0] b, input int p);
    return b + 32'(p) * iqcm_pkg::PORT_STRIDE;
  endfunction

  task automatic cfg(input int p, input int dep, input int per, input int lim, input int cnt);
    wr(adr(iqcm_pkg::DEPTH_CFG_OFS, p), {16'(per), 4'(dep), 12'h000});
    wr(adr(iqcm_pkg::EVT_STATUS_OFS, p), {16'(cnt), 16'(lim)});
    m_dep[p] = dep;
    m_per[p] = per;
    m_lim[p] = lim;
    m_evt[p] = cnt;
  endtask

  task automatic pkts(input int n);
    repeat (n) begin
      fix_pkt <= 1'b1;
      @(posedge clk);
      fix_pkt <= 1'b0;
      @(posedge clk);
    end
    repeat (3) @(posedge clk);
  endtask

  initial begin
    resetn = 1'b0;
    hsel = 1'b0;
    htrans = 2'b00;
    haddr = 32'h0000_0000;
    hwrite = 1'b0;
    hsize = 3'h2;
    sz = 3'h2;
    hwdata = 32'h0000_0000;
    rnd_en = 1'b0;
    fix_fill = 4'h0;
    fix_pkt = 1'b0;
    ra = '{iqcm_pkg::DEPTH_CFG_OFS, iqcm_pkg::EVT_STATUS_OFS, iqcm_pkg::DURATION_OFS,
      iqcm_pkg::IRQ_STATUS_OFS, iqcm_pkg::IRQ_MASK_OFS, iqcm_pkg::BIAS_INTERVAL_OFS,
      32'h0001_380C};
    void'($urandom(32'h67FD));
    repeat (4) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    foreach (ra[i]) rdc(ra[i], 32'h0000_0000, "reset value");
    wr(32'h0001_380C, 32'hFFFF_FFFF);
    rdc(32'h0001_380C, 32'h0000_0000, "unmapped write");
    wr(iqcm_pkg::IRQ_MASK_OFS, 32'h0000_00FF);
    rdc(iqcm_pkg::IRQ_MASK_OFS, 32'h0000_00FF, "mask readback");
    // A byte-sized write must leave the register untouched.
    sz = 3'h0;
    wr(iqcm_pkg::IRQ_MASK_OFS, 32'h0000_0000);
    sz = 3'h2;
    rdc(iqcm_pkg::IRQ_MASK_OFS, 32'h0000_00FF, "narrow write ignored");
    // Every port gets its own depth and divisor, limit 256 except zero on port 1; two passes cover depths 0 to 8.
    for (int ph = 0; ph < 2; ph++) begin
      for (int p = 0; p < NP; p++) cfg(p, p + ph, p, (p == 1) ? 0 : 256, 0);
      rnd_en <= 1'b1;
      repeat (300) @(posedge clk);
      rnd_en <= 1'b0;
      repeat (4) @(posedge clk);
      for (int p = 0; p < NP; p++) begin
        rdc(adr(iqcm_pkg::EVT_STATUS_OFS, p), {16'(m_evt[p]), 16'(m_lim[p])}, "count");
        rdc(adr(iqcm_pkg::DURATION_OFS, p), 32'(m_dur[p]), "duration");
        m_dur[p] = 0;
      end
    end
    wr(iqcm_pkg::IRQ_MASK_OFS, 32'h0000_0004);
    cfg(2, 3, 2, 16, 14);
    fix_fill <= 4'h4;
    pkts(1);
    chk({31'h0, irq}, 32'h0000_0000, "irq below limit");
    pkts(1);
    chk({31'h0, irq}, 32'h0000_0001, "irq at limit");
    rdc(iqcm_pkg::IRQ_STATUS_OFS, 32'h0000_0004, "flag set");
    wr(iqcm_pkg::IRQ_MASK_OFS, 32'h0000_0000);
    @(negedge clk);
    chk({31'h0, irq}, 32'h0000_0000, "irq masked");
    wr(iqcm_pkg::IRQ_MASK_OFS, 32'h0000_0004);
    @(negedge clk);
    chk({31'h0, irq}, 32'h0000_0001, "irq unmasked");
    wr(iqcm_pkg::IRQ_STATUS_OFS, 32'h0000_0004);
    m_evt[2] = 0;
    @(negedge clk);
    chk({31'h0, irq}, 32'h0000_0000, "irq cleared");
    rdc(adr(iqcm_pkg::EVT_STATUS_OFS, 2), 32'h0000_0010, "count cleared");
    wr(iqcm_pkg::IRQ_MASK_OFS, 32'h0000_0000);
    cfg(2, 3, 2, 16, 65534);
    pkts(3);
    rdc(adr(iqcm_pkg::EVT_STATUS_OFS, 2), 32'hFFFF_0010, "count saturates");
    wr(iqcm_pkg::IRQ_STATUS_OFS, 32'h0000_0004);
    rdc(adr(iqcm_pkg::EVT_STATUS_OFS, 2), 32'h0000_0010, "saturated count cleared");
    fix_fill <= 4'h0;
    repeat (3) @(posedge clk);
    wr(adr(iqcm_pkg::DURATION_OFS, 3), 32'h0000_FFFD);
    fix_fill <= 4'hF;
    repeat (20) @(posedge clk);
    fix_fill <= 4'h0;
    repeat (4) @(posedge clk);
    rdc(adr(iqcm_pkg::DURATION_OFS, 3), 32'h0000_FFFF, "duration saturates");
    rdc(adr(iqcm_pkg::DURATION_OFS, 3), 32'h0000_0000, "read clears");
    // One interval passes unread, then the next passes after a read.
    wr(iqcm_pkg::BIAS_INTERVAL_OFS, 32'd100);
    // The first tick only forgets the read made before the interval was set.
    repeat (110) @(posedge clk);
    wr(adr(iqcm_pkg::EVT_STATUS_OFS, 2), 32'h0005_0010);
    repeat (150) @(posedge clk);
    rdc(adr(iqcm_pkg::EVT_STATUS_OFS, 2), 32'h0004_0010, "unread decrement");
    repeat (60) @(posedge clk);
    rdc(adr(iqcm_pkg::EVT_STATUS_OFS, 2), 32'h0004_0010, "read keeps count");
    wr(iqcm_pkg::BIAS_INTERVAL_OFS, 32'h0000_0000);
    test_done();
  end
endmodule
